//--- rns_pkg.sv
// constants and types shared by the receive statistics counter bank
`default_nettype none
package rns_pkg;
    localparam int          RNS_NUM_CNT       = 8;
    localparam int          RNS_LEN_W         = 16;
    // counter indices; byte address is four times the index
    localparam logic [2:0]  RNS_IDX_GOOD      = 3'h0;
    localparam logic [2:0]  RNS_IDX_BCAST     = 3'h1;
    localparam logic [2:0]  RNS_IDX_GROUP     = 3'h2;
    localparam logic [2:0]  RNS_IDX_PAUSE     = 3'h3;
    localparam logic [2:0]  RNS_IDX_FCS       = 3'h4;
    localparam logic [2:0]  RNS_IDX_ALIGN     = 3'h5;
    localparam logic [2:0]  RNS_IDX_TOO_LONG  = 3'h6;
    localparam logic [2:0]  RNS_IDX_LONG_BAD  = 3'h7;
    localparam logic [7:0]  RNS_OFS_CNT_BASE  = 8'h00;
    localparam logic [7:0]  RNS_OFS_CNT_END   = 8'h1C;
    localparam logic [7:0]  RNS_OFS_MAC_CTRL  = 8'h20;
    localparam logic [7:0]  RNS_OFS_MAX_LEN   = 8'h24;
    localparam logic [7:0]  RNS_OFS_STATUS    = 8'h28;
    // mac_control_register fields and the status register pending bit
    localparam int          RNS_CTRL_GIE_BIT  = 0;
    localparam int          RNS_CTRL_TXFL_BIT = 4;
    localparam int          RNS_CTRL_SIE_BIT  = 5;
    localparam logic [31:0] RNS_CTRL_MASK     = 32'h0000_0031;
    localparam int          RNS_STAT_PEND_BIT = 0;
    // reset values
    localparam logic [31:0] RNS_CTRL_RST      = 32'h0000_0000;
    localparam logic [15:0] RNS_MAX_LEN_RST   = 16'h05EE;
    localparam logic [31:0] RNS_CNT_RST       = 32'h0000_0000;
    // frame and threshold figures
    localparam logic [15:0] RNS_MIN_LEN       = 16'h0040;
    localparam logic [31:0] RNS_HALF_RANGE    = 32'h8000_0000;
    localparam logic [31:0] RNS_ALL_ONES      = 32'hFFFF_FFFF;
    localparam logic [3:0]  RNS_FULL_WORD_BE  = 4'hF;
    // counters are cleared this many clocks after reset release
    localparam int          RNS_CLEAR_CLOCKS  = 38;
    localparam logic [5:0]  RNS_CLEAR_LAST    = 6'(RNS_CLEAR_CLOCKS - 1);

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } rns_av_req_t;

    // per-frame status from the receive path, valid for one cycle at frame end
    typedef struct packed {
        logic        valid;
        logic        accepted;
        logic        broadcast;
        logic        group;
        logic        pause_type;
        logic        odd_nibble;
        logic        fcs_fail;
        logic        fcs_fail_trunc;
        logic        overrun;
        logic [15:0] length;
    } rns_frame_status_t;
endpackage : rns_pkg
`default_nettype wire

//--- rns_stats.sv
// receive network statistics counter bank with avalon-mm register slave
//
// Summary of operation
// - clear all counters 38 clocks after reset
// - decrement mode: write subtracts value from counter
// - decrement below zero stores zero
// - direct mode: write loads the value
// - pending while enabled and any counter >= half
// - pending drops once counters fall below half
// - 32-bit counters wrap from all ones
// - count good accepted legal-length error-free frames
// - count good frames to broadcast address
// - count good group frames, not broadcast
// - count legal error-free pause frames when flow enabled
// - count even-nibble fcs failures without other errors
// - odd nibble plus truncated fcs failure: alignment
// - error input during frame: code error, discard
// - count too-long error-free accepted frames
// - count too-long accepted frames with errors
// - overrun has no effect on counting
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`default_nettype none
module rns_stats
    import rns_pkg::*;
#(
    parameter int LEN_W = RNS_LEN_W
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire rns_av_req_t       avs_req,
    output logic                   avs_waitrequest,
    output logic [31:0]            avs_readdata,
    input  wire rns_frame_status_t rx_status,
    input  wire logic              rx_in_frame,
    input  wire logic              receive_error_input,
    output logic                   statistics_interrupt_pending,
    output logic                   code_error_discard
);

    function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
        sat_sub = (b > a) ? 32'h0000_0000 : a - b;
    endfunction : sat_sub

    // ---------------- bus slave and configuration ----------------
    logic              wait_q,   wait_d;
    logic [31:0]       rdata_q,  rdata_d;
    logic [31:0]       ctrl_q,   ctrl_d;
    logic [LEN_W-1:0]  maxlen_q, maxlen_d;
    logic              pend_q,   pend_d;
    logic [5:0]        clr_cnt_q, clr_cnt_d;
    logic              clr_done_q, clr_done_d;
    logic [31:0]       cnt_q [RNS_NUM_CNT];
    logic [31:0]       cnt_d [RNS_NUM_CNT];

    logic              req;
    logic              accept;
    logic              cnt_sel;
    logic [2:0]        cnt_idx;
    logic              cnt_wr;
    logic              clr_pulse;
    logic              any_half;

    assign req     = avs_req.read | avs_req.write;
    assign accept  = req & ~wait_q;
    assign cnt_sel = avs_req.address <= RNS_OFS_CNT_END;
    assign cnt_idx = avs_req.address[4:2];
    // narrow writes to a counter are dropped rather than merged
    assign cnt_wr  = accept & avs_req.write & cnt_sel & (avs_req.byteenable == RNS_FULL_WORD_BE);
    assign clr_pulse = ~clr_done_q & (clr_cnt_q == RNS_CLEAR_LAST);

    always_comb begin
        any_half = 1'b0;
        for (int i = 0; i < RNS_NUM_CNT; i++) begin
            any_half = any_half | (cnt_q[i] >= RNS_HALF_RANGE);
        end
    end

    always_comb begin
        wait_d     = 1'b1;
        rdata_d    = rdata_q;
        ctrl_d     = ctrl_q;
        maxlen_d   = maxlen_q;
        clr_cnt_d  = clr_cnt_q;
        clr_done_d = clr_done_q;
        if (!clr_done_q) begin
            clr_cnt_d = clr_cnt_q + 6'h01;
        end
        if (clr_pulse) begin
            clr_done_d = 1'b1;
        end
        // one wait cycle per access; accesses stall until the start-up clear is over
        if (req && wait_q && clr_done_q) begin
            wait_d = 1'b0;
            if (cnt_sel) begin
                rdata_d = cnt_q[cnt_idx];
            end else if (avs_req.address == RNS_OFS_MAC_CTRL) begin
                rdata_d = ctrl_q;
            end else if (avs_req.address == RNS_OFS_MAX_LEN) begin
                rdata_d = 32'(maxlen_q);
            end else if (avs_req.address == RNS_OFS_STATUS) begin
                rdata_d = 32'(pend_q) << RNS_STAT_PEND_BIT;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
        if (accept && avs_req.write) begin
            if (avs_req.address == RNS_OFS_MAC_CTRL) begin
                ctrl_d = avs_req.writedata & RNS_CTRL_MASK;
            end
            if (avs_req.address == RNS_OFS_MAX_LEN) begin
                maxlen_d = avs_req.writedata[LEN_W-1:0];
            end
        end
        // level recomputed every cycle so decrementing writes remove it
        pend_d = ctrl_q[RNS_CTRL_SIE_BIT] & any_half;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_q     <= 1'b1;
            rdata_q    <= 32'h0000_0000;
            ctrl_q     <= RNS_CTRL_RST;
            maxlen_q   <= LEN_W'(RNS_MAX_LEN_RST);
            pend_q     <= 1'b0;
            clr_cnt_q  <= 6'h00;
            clr_done_q <= 1'b0;
        end else begin
            wait_q     <= wait_d;
            rdata_q    <= rdata_d;
            ctrl_q     <= ctrl_d;
            maxlen_q   <= maxlen_d;
            pend_q     <= pend_d;
            clr_cnt_q  <= clr_cnt_d;
            clr_done_q <= clr_done_d;
        end
    end

    assign avs_waitrequest              = wait_q;
    assign avs_readdata                 = rdata_q;
    assign statistics_interrupt_pending = pend_q;

    // ---------------- frame status pipeline ----------------
    // status is delayed two cycles to line up with the synchronised error pin
    logic              err_meta_q, err_sync_q;
    rns_frame_status_t st1_q, st2_q;
    logic              inf1_q, inf2_q;
    logic              code_seen_q, code_seen_d;
    logic              discard_q, discard_d;
    logic              code_now;

    always_comb begin
        code_now    = code_seen_q | (err_sync_q & inf2_q);
        code_seen_d = st2_q.valid ? 1'b0 : code_now;
        discard_d   = st2_q.valid & code_now;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            err_meta_q  <= 1'b0;
            err_sync_q  <= 1'b0;
            st1_q       <= '0;
            st2_q       <= '0;
            inf1_q      <= 1'b0;
            inf2_q      <= 1'b0;
            code_seen_q <= 1'b0;
            discard_q   <= 1'b0;
        end else begin
            err_meta_q  <= receive_error_input;
            err_sync_q  <= err_meta_q;
            st1_q       <= rx_status;
            st2_q       <= st1_q;
            inf1_q      <= rx_in_frame;
            inf2_q      <= inf1_q;
            code_seen_q <= code_seen_d;
            discard_q   <= discard_d;
        end
    end

    assign code_error_discard = discard_q;

    // ---------------- classification ----------------
    logic                   crc_err, align_err, any_err, legal_len, too_long, good;
    logic [RNS_NUM_CNT-1:0] inc;

    always_comb begin
        crc_err   = ~st2_q.odd_nibble & st2_q.fcs_fail;
        align_err = st2_q.odd_nibble & st2_q.fcs_fail_trunc;
        any_err   = crc_err | align_err | code_now;
        // the overrun flag is deliberately not looked at
        legal_len = (st2_q.length >= RNS_MIN_LEN) && (LEN_W'(st2_q.length) <= maxlen_q);
        too_long  = LEN_W'(st2_q.length) > maxlen_q;
        good      = st2_q.valid & st2_q.accepted & legal_len & ~any_err;
        inc       = '0;
        inc[RNS_IDX_GOOD]     = good;
        inc[RNS_IDX_BCAST]    = good & st2_q.broadcast;
        inc[RNS_IDX_GROUP]    = good & st2_q.group & ~st2_q.broadcast;
        inc[RNS_IDX_PAUSE]    = good & st2_q.pause_type & ctrl_q[RNS_CTRL_TXFL_BIT];
        inc[RNS_IDX_FCS]      = st2_q.valid & st2_q.accepted & legal_len & ~align_err & ~code_now & crc_err;
        inc[RNS_IDX_ALIGN]    = st2_q.valid & st2_q.accepted & legal_len & (align_err | code_now);
        inc[RNS_IDX_TOO_LONG] = st2_q.valid & st2_q.accepted & too_long & ~any_err;
        inc[RNS_IDX_LONG_BAD] = st2_q.valid & st2_q.accepted & too_long & any_err;
    end

    // ---------------- counters ----------------
    // a host write and a frame event in one cycle: write applied first, then the event
    always_comb begin
        for (int i = 0; i < RNS_NUM_CNT; i++) begin
            cnt_d[i] = cnt_q[i];
            if (cnt_wr && (cnt_idx == 3'(i))) begin
                if (ctrl_q[RNS_CTRL_GIE_BIT]) begin
                    cnt_d[i] = sat_sub(cnt_q[i], avs_req.writedata);
                end else begin
                    cnt_d[i] = avs_req.writedata;
                end
            end
            cnt_d[i] = cnt_d[i] + 32'(inc[i]);
            if (clr_pulse) begin
                cnt_d[i] = RNS_CNT_RST;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < RNS_NUM_CNT; i++) begin
                cnt_q[i] <= RNS_CNT_RST;
            end
        end else begin
            for (int i = 0; i < RNS_NUM_CNT; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // ---------------- assertions ----------------
    logic        wr_good;
    assign wr_good = cnt_wr & (cnt_idx == RNS_IDX_GOOD);

    sequence s_clear_fires;
        clr_pulse ##1 clr_done_q;
    endsequence

    property p_clear_zero;
        @(posedge clk) disable iff (reset)
        s_clear_fires |-> (cnt_q[0] == 32'h0) && (cnt_q[3] == 32'h0) && (cnt_q[7] == 32'h0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("counters not zero after start-up clear");

    property p_clear_time;
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> ##37 (clr_pulse && !clr_done_q);
    endproperty
    a_clear_time: assert property (p_clear_time) else $error("start-up clear at wrong clock");

    property p_dec_write;
        @(posedge clk) disable iff (reset)
        (wr_good && ctrl_q[RNS_CTRL_GIE_BIT] && !inc[RNS_IDX_GOOD] && !clr_pulse)
        |=> cnt_q[0] == (($past(avs_req.writedata) > $past(cnt_q[0])) ? 32'h0 : $past(cnt_q[0]) - $past(avs_req.writedata));
    endproperty
    a_dec_write: assert property (p_dec_write) else $error("decrementing write wrong");

    property p_direct_write;
        @(posedge clk) disable iff (reset)
        (wr_good && !ctrl_q[RNS_CTRL_GIE_BIT] && !inc[RNS_IDX_GOOD] && !clr_pulse)
        |=> cnt_q[0] == $past(avs_req.writedata);
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("direct write not loaded");

    property p_pend_set;
        @(posedge clk) disable iff (reset)
        (ctrl_q[RNS_CTRL_SIE_BIT] && (cnt_q[0] >= RNS_HALF_RANGE)) |=> statistics_interrupt_pending;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending missing above half range");

    property p_pend_drop;
        @(posedge clk) disable iff (reset)
        !any_half |=> !statistics_interrupt_pending;
    endproperty
    a_pend_drop: assert property (p_pend_drop) else $error("pending held below half range");

    property p_wrap;
        @(posedge clk) disable iff (reset)
        (inc[RNS_IDX_GOOD] && (cnt_q[0] == RNS_ALL_ONES) && !wr_good && !clr_pulse) |=> cnt_q[0] == 32'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_good_count;
        @(posedge clk) disable iff (reset)
        (st2_q.valid && st2_q.accepted && legal_len && !any_err && !wr_good && !clr_pulse)
        |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1;
    endproperty
    a_good_count: assert property (p_good_count) else $error("good frame not counted");

    property p_once_per_frame;
        @(posedge clk) disable iff (reset)
        (inc != '0) |-> st2_q.valid ##1 (inc == '0);
    endproperty
    a_once_per_frame: assert property (p_once_per_frame) else $error("counted outside one frame end");

    property p_long_exclusive;
        @(posedge clk) disable iff (reset)
        !(inc[RNS_IDX_TOO_LONG] && (inc[RNS_IDX_LONG_BAD] || inc[RNS_IDX_GOOD]));
    endproperty
    a_long_exclusive: assert property (p_long_exclusive) else $error("too-long frame counted twice");

    property p_bcast_group;
        @(posedge clk) disable iff (reset)
        (inc[RNS_IDX_BCAST] || inc[RNS_IDX_GROUP]) |-> inc[RNS_IDX_GOOD] && !(inc[RNS_IDX_BCAST] && inc[RNS_IDX_GROUP]);
    endproperty
    a_bcast_group: assert property (p_bcast_group) else $error("broadcast or group count without good");

    property p_discard;
        @(posedge clk) disable iff (reset)
        (st2_q.valid && code_now) |=> code_error_discard ##1 !code_error_discard;
    endproperty
    a_discard: assert property (p_discard) else $error("code error discard pulse wrong");

    // classification checks, one frame end at a time
    property p_bcast_count;
        @(posedge clk) disable iff (reset)
        (inc[RNS_IDX_GOOD] && st2_q.broadcast) |-> inc[RNS_IDX_BCAST];
    endproperty
    a_bcast_count: assert property (p_bcast_count) else $error("good broadcast frame not counted");

    property p_group_count;
        @(posedge clk) disable iff (reset)
        (inc[RNS_IDX_GOOD] && st2_q.group && !st2_q.broadcast) |-> inc[RNS_IDX_GROUP];
    endproperty
    a_group_count: assert property (p_group_count) else $error("good group frame not counted");

    property p_pause_count;
        @(posedge clk) disable iff (reset)
        inc[RNS_IDX_PAUSE] == (inc[RNS_IDX_GOOD] && st2_q.pause_type && ctrl_q[RNS_CTRL_TXFL_BIT]);
    endproperty
    a_pause_count: assert property (p_pause_count) else $error("pause count disagrees with its conditions");

    property p_fcs_count;
        @(posedge clk) disable iff (reset)
        inc[RNS_IDX_FCS] |-> st2_q.accepted && legal_len && !st2_q.odd_nibble && st2_q.fcs_fail && !code_now;
    endproperty
    a_fcs_count: assert property (p_fcs_count) else $error("fcs error counted without its conditions");

    property p_align_count;
        @(posedge clk) disable iff (reset)
        (st2_q.valid && st2_q.accepted && legal_len && st2_q.odd_nibble && st2_q.fcs_fail_trunc)
        |-> inc[RNS_IDX_ALIGN] && !inc[RNS_IDX_FCS] && !inc[RNS_IDX_GOOD];
    endproperty
    a_align_count: assert property (p_align_count) else $error("alignment error not counted");

    property p_code_count;
        @(posedge clk) disable iff (reset)
        (st2_q.valid && st2_q.accepted && legal_len && code_now)
        |-> inc[RNS_IDX_ALIGN] && !inc[RNS_IDX_FCS] && !inc[RNS_IDX_GOOD];
    endproperty
    a_code_count: assert property (p_code_count) else $error("code error not counted");

    property p_too_long_count;
        @(posedge clk) disable iff (reset)
        (st2_q.valid && st2_q.accepted && too_long)
        |-> (inc[RNS_IDX_TOO_LONG] == !any_err) && (inc[RNS_IDX_LONG_BAD] == any_err);
    endproperty
    a_too_long_count: assert property (p_too_long_count) else $error("too-long frame misclassified");

    property p_narrow_ignored;
        @(posedge clk) disable iff (reset)
        (accept && avs_req.write && (avs_req.address == RNS_OFS_CNT_BASE)
            && (avs_req.byteenable != RNS_FULL_WORD_BE) && !inc[RNS_IDX_GOOD] && !clr_pulse)
        |=> cnt_q[0] == $past(cnt_q[0]);
    endproperty
    a_narrow_ignored: assert property (p_narrow_ignored) else $error("narrow counter write changed count");

endmodule : rns_stats
`default_nettype wire

//--- rns_rx_model.sv
// receive path model: frame window, error pin and end-of-frame status
`default_nettype none
module rns_rx_model
    import rns_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              go,
    input  wire rns_frame_status_t fr,
    input  wire logic              err,
    output rns_frame_status_t      rx_status,
    output logic                   rx_in_frame,
    output logic                   receive_error_input,
    output logic                   busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    initial begin
        rx_status = '0;
        rx_in_frame = 1'b0;
        receive_error_input = 1'b0;
        busy = 1'b0;
        n = 0;
    end
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            n <= 0;
            rx_in_frame <= 1'b1;
        end else if (busy) begin
            n <= n + 1;
            // error held three clocks so it survives the two-flop input stage
            receive_error_input <= err && n < 3;
            if (n == 4) rx_in_frame <= 1'b0;
            if (n == 5) begin
                rx_status <= {1'b1, fr[$bits(fr)-2:0]};
            end
            // status fields stop meaning anything once valid drops
            if (n == 6) begin
                rx_status <= {1'b0, ~rx_status[$bits(rx_status)-2:0]};
                busy <= 1'b0;
            end
        end
    end
endmodule : rns_rx_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the receive statistics counter bank
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb
    import rns_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk, reset, wreq, pend, disc, go, err, busy, inf, rxer;
    rns_av_req_t       req;
    rns_frame_status_t st, fr, f;
    logic [31:0]       rdata, seed, ctrl, q, cnt[8];
    logic [15:0]       mlen;
    int                fail_count, checks, cyc, ndisc, edisc, t0;

    rns_stats i_dut (.clk(clk), .reset(reset), .avs_req(req), .avs_waitrequest(wreq),
        .avs_readdata(rdata), .rx_status(st), .rx_in_frame(inf), .receive_error_input(rxer),
        .statistics_interrupt_pending(pend), .code_error_discard(disc));
    rns_rx_model i_rx (.clk(clk), .go(go), .fr(fr), .err(err), .rx_status(st),
        .rx_in_frame(inf), .receive_error_input(rxer), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (disc === 1'b1) ndisc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    function automatic logic exp_pend();
        logic any;
        any = 1'b0;
        for (int i = 0; i < 8; i++) any |= cnt[i] >= RNS_HALF_RANGE;
        return ctrl[RNS_CTRL_SIE_BIT] & any;
    endfunction : exp_pend
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        if (a <= RNS_OFS_CNT_END) return cnt[a[4:2]];
        if (a == RNS_OFS_MAC_CTRL) return ctrl;
        if (a == RNS_OFS_MAX_LEN) return {16'h0000, mlen};
        if (a == RNS_OFS_STATUS) return {31'h0, exp_pend()};
        return 32'h0000_0000;
    endfunction : exp_rd

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int t;
        @(posedge clk);
        req <= '{read: !w, write: w, address: a, byteenable: be, writedata: d};
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (wreq !== 1'b0 && t < 400);
        if (t >= 400) fail_count++;
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        // narrow counter writes are acknowledged but leave the count alone
        if (a <= RNS_OFS_CNT_END && be == RNS_FULL_WORD_BE)
            cnt[a[4:2]] = ctrl[RNS_CTRL_GIE_BIT] ? (d > cnt[a[4:2]] ? 32'h0 : cnt[a[4:2]] - d) : d;
        else if (a == RNS_OFS_MAC_CTRL) ctrl = d & RNS_CTRL_MASK;
        else if (a == RNS_OFS_MAX_LEN) mlen = d[15:0];
    endtask : wr
    task automatic chk_all(input string nm);
        for (int k = 0; k < 12; k++) begin
            bus(1'b0, 8'(k * 4), 32'h0, RNS_FULL_WORD_BE);
            `CHK("register", exp_rd(8'(k * 4)), q)
        end
        `CHK("pending pin", exp_pend(), pend)
        $display("test %s done", nm);
    endtask : chk_all
    task automatic frame(input rns_frame_status_t s, input logic e);
        logic al, crc, bad, leg;
        @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
        fr <= s;
        err <= e;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (12) @(posedge clk);
        al = s.odd_nibble & s.fcs_fail_trunc;
        crc = !s.odd_nibble & s.fcs_fail;
        bad = al | crc | e;
        leg = s.length >= RNS_MIN_LEN && s.length <= mlen;
        if (s.accepted) begin
            if (leg && !bad) begin
                cnt[0]++;
                if (s.broadcast) cnt[1]++;
                else if (s.group) cnt[2]++;
                if (s.pause_type && ctrl[RNS_CTRL_TXFL_BIT]) cnt[3]++;
            end
            if (leg && crc && !al && !e) cnt[4]++;
            if (leg && (al || e)) cnt[5]++;
            if (s.length > mlen) cnt[bad ? 7 : 6]++;
        end
        if (e) edisc++;
    endtask : frame
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset(input logic mid_clear);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        foreach (cnt[i]) cnt[i] = RNS_CNT_RST;
        ctrl = RNS_CTRL_RST;
        mlen = RNS_MAX_LEN_RST;
        t0 = cyc;
        // a good frame inside the clear window must not survive the clear
        if (mid_clear) begin
            frame(f, 1'b0);
            foreach (cnt[i]) cnt[i] = RNS_CNT_RST;
        end
        bus(1'b0, RNS_OFS_CNT_BASE, 32'h0, RNS_FULL_WORD_BE);
        `CHK("clear wait", 1'b1, (cyc - t0) >= RNS_CLEAR_CLOCKS)
    endtask : do_reset

    initial begin
        reset = 1'b1;
        req = '0;
        go = 1'b0;
        err = 1'b0;
        fr = '0;
        seed = 32'h0000_0029;
        do_reset(1'b0);
        chk_all("reset");
        wr(RNS_OFS_MAC_CTRL, 32'hFFFF_FFFF, RNS_FULL_WORD_BE);
        chk_all("control mask");
        wr(RNS_OFS_MAC_CTRL, 32'h0000_0030, RNS_FULL_WORD_BE);
        wr(RNS_OFS_MAX_LEN, 32'h0000_0064, RNS_FULL_WORD_BE);
        for (int i = 0; i < 64; i++) begin
            q = xorshift();
            f = '0;
            f.accepted = q[0] | q[1];
            f.broadcast = q[2] & q[3];
            f.group = q[4] | f.broadcast;
            f.pause_type = q[5];
            f.odd_nibble = q[6] & q[7];
            f.fcs_fail = q[8] & q[9];
            f.fcs_fail_trunc = q[10];
            f.overrun = q[11];
            case (q[14:12])
                3'h0: f.length = 16'h003F;
                3'h1: f.length = 16'h0040;
                3'h2: f.length = 16'h0064;
                3'h3: f.length = 16'h0065;
                default: f.length = {4'h0, q[31:20]};
            endcase
            frame(f, q[15] & q[16]);
            if (i == 32) wr(RNS_OFS_MAC_CTRL, 32'h0000_0020, RNS_FULL_WORD_BE);
            chk_all("frame");
        end
        for (int i = 0; i < 8; i++) wr(8'(i * 4), xorshift(), RNS_FULL_WORD_BE);
        chk_all("direct load");
        f = '0;
        f.accepted = 1'b1;
        f.length = RNS_MIN_LEN;
        wr(RNS_OFS_CNT_BASE, RNS_ALL_ONES, RNS_FULL_WORD_BE);
        for (int i = 1; i < 8; i++) wr(8'(i * 4), 32'h0, RNS_FULL_WORD_BE);
        frame(f, 1'b0);
        chk_all("wrap");
        wr(RNS_OFS_CNT_BASE, 32'h7FFF_FFFF, RNS_FULL_WORD_BE);
        frame(f, 1'b0);
        chk_all("half range");
        wr(RNS_OFS_MAC_CTRL, 32'h0000_0021, RNS_FULL_WORD_BE);
        wr(RNS_OFS_CNT_BASE, 32'h0000_0001, 4'h3);
        chk_all("narrow write");
        wr(RNS_OFS_CNT_BASE, 32'h0000_0001, RNS_FULL_WORD_BE);
        chk_all("decrement");
        wr(RNS_OFS_CNT_BASE, RNS_HALF_RANGE, RNS_FULL_WORD_BE);
        wr(8'h04, RNS_ALL_ONES, RNS_FULL_WORD_BE);
        chk_all("saturate");
        wr(RNS_OFS_MAC_CTRL, 32'h0000_0000, RNS_FULL_WORD_BE);
        wr(RNS_OFS_CNT_BASE, RNS_ALL_ONES, RNS_FULL_WORD_BE);
        chk_all("interrupt off");
        do_reset(1'b1);
        chk_all("second reset");
        `CHK("discard pulses", edisc, ndisc)
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
